// [rtl/flash_program_erase_control.sv]
// The address-and-strobe port was chosen for this implementation.
`timescale 1ns/1ps
`include "flash_ctl_params.svh"
module flash_program_erase_control
  import flash_ctl_pkg::*;
(
  // clock and reset
  input wire logic sys_clk,
  input wire logic rst_n,
  // register port
  input wire addr_t reg_addr,
  input wire byte_t reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output byte_t reg_rdata,
  // security
  input wire logic ext_access,
  input wire logic secured,
  // array status
  output logic charge_pump_on,
  output logic high_voltage_array,
  output byte_t osc_trim,
  output byte_t protect_boundary
);
  // ****************
  // state
  // ****************
  logic program_select;
  logic erase_select;
  logic mass_select;
  logic high_voltage_enable;
  seq_state_e seq;
  addr_t target;
  logic [`ROW_LSB+10:`ROW_LSB] row_id;
  logic locked;
  byte_t arr_rdata;
  logic [`FLASH_AW-1:0] arr_addr;
  logic rd_flash_q;
  logic rd_ctl_q;
  logic hide_q;
  logic boot_load;
  logic boot_done;
  logic prog_en;
  logic page_erase;
  logic mass_erase;
  logic in_flash;
  logic wr_ctl;
  logic wr_flash;
  logic hv_allowed;
  logic osc_trim_reload_pending;
  byte_t next_ctl;

  // ****************
  // address decode
  // ****************
  function automatic logic ctl_hit(input addr_t a);
    ctl_hit = a == `FCTL_OFF;
  endfunction : ctl_hit

  // the control register sits inside the flash window but is never a flash cell
  function automatic logic flash_hit(input addr_t a);
    flash_hit = a >= `FLASH_BASE && !ctl_hit(a);
  endfunction : flash_hit

  function automatic logic [`ROW_LSB+10:`ROW_LSB] row_of(input addr_t a);
    row_of = a[`ROW_LSB+10:`ROW_LSB];
  endfunction : row_of

  assign in_flash = flash_hit(reg_addr);
  assign wr_ctl = reg_wr && ctl_hit(reg_addr);
  assign wr_flash = reg_wr && in_flash;

  // ****************
  // control register write
  // ****************
  always_comb begin
    next_ctl = reg_wdata & `FCTL_WMASK;
    if (next_ctl[`FCTL_ERASE_BIT] && next_ctl[`FCTL_PGM_BIT]) begin
      next_ctl[`FCTL_PGM_BIT] = program_select;
      next_ctl[`FCTL_ERASE_BIT] = erase_select & ~program_select;
    end
    if (program_select && next_ctl[`FCTL_ERASE_BIT]) begin
      next_ctl[`FCTL_ERASE_BIT] = 1'b0;
    end
    if (erase_select && next_ctl[`FCTL_PGM_BIT]) begin
      next_ctl[`FCTL_PGM_BIT] = 1'b0;
    end
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      program_select <= 1'b0;
      erase_select <= 1'b0;
      mass_select <= 1'b0;
    end else if (wr_ctl) begin
      program_select <= next_ctl[`FCTL_PGM_BIT];
      erase_select <= next_ctl[`FCTL_ERASE_BIT];
      mass_select <= next_ctl[`FCTL_MASS_BIT];
    end
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      high_voltage_enable <= 1'b0;
    end else if (wr_ctl) begin
      // only the latched step may raise it; clearing is always allowed
      high_voltage_enable <= next_ctl[`FCTL_HIGH_VOLTAGE_ENABLE_BIT] && (high_voltage_enable || hv_allowed);
    end
  end

  // a protected target keeps the pump off for program and erase alike
  assign hv_allowed = seq == SEQ_LATCHED && !locked && (program_select || erase_select);

  // ****************
  // sequence tracking
  // ****************
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      seq <= SEQ_IDLE;
    end else if (!program_select && !erase_select && !high_voltage_enable) begin
      seq <= SEQ_IDLE;
    end else begin
      case (seq)
        SEQ_IDLE: begin
          seq <= SEQ_ARMED;
        end
        SEQ_ARMED: begin
          if (reg_rd && reg_addr == `FBPR_OFF) begin
            seq <= SEQ_BPR_READ;
          end
        end
        SEQ_BPR_READ: begin
          if (wr_flash) begin
            seq <= SEQ_LATCHED;
          end
        end
        SEQ_LATCHED: begin
          if (high_voltage_enable) begin
            seq <= SEQ_HIGH_V;
          end
        end
        SEQ_HIGH_V: begin
          seq <= SEQ_HIGH_V;
        end
        default: begin
          seq <= SEQ_IDLE;
        end
      endcase
    end
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      target <= 16'h0000;
    end else if (seq == SEQ_BPR_READ && wr_flash) begin
      target <= reg_addr;
    end
  end

  // the row of the latched address bounds every program write
  assign row_id = row_of(target);

  flash_protect_check u_protect (
    .boundary(protect_boundary),
    .target(target),
    .mass_sel(mass_select & erase_select),
    .locked(locked)
  );

  // ****************
  // array strobes
  // ****************
  // writes outside the latched row are dropped rather than corrupting a neighbour
  assign prog_en = boot_done && high_voltage_enable && program_select && wr_flash &&
    row_of(reg_addr) == row_id;
  assign page_erase = boot_done && high_voltage_enable && erase_select && !mass_select &&
    wr_ctl && !next_ctl[`FCTL_ERASE_BIT];
  assign mass_erase = boot_done && high_voltage_enable && erase_select && mass_select &&
    wr_ctl && !next_ctl[`FCTL_ERASE_BIT];

  // boot reads come first; erase addresses the latched page, all else follows the bus
  always_comb begin
    if (!boot_done) begin
      arr_addr = boot_load ? `FLASH_AW'(`FTRIM_OFF - `FLASH_BASE) : `FLASH_AW'(`FBPR_OFF - `FLASH_BASE);
    end else if (page_erase) begin
      arr_addr = target[`FLASH_AW-1:0];
    end else begin
      arr_addr = reg_addr[`FLASH_AW-1:0];
    end
  end

  flash_array_mem u_array (
    .sys_clk(sys_clk),
    .addr(arr_addr),
    .prog_en(prog_en),
    .prog_data(reg_wdata),
    .page_erase(page_erase),
    .mass_erase(mass_erase),
    .rd_data(arr_rdata)
  );

  // ****************
  // boot load of trim and protect bytes
  // ****************
  // two reads after reset: protect byte, then trim byte
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      boot_load <= 1'b0;
      boot_done <= 1'b0;
    end else if (!boot_done) begin
      boot_load <= 1'b1;
      boot_done <= boot_load;
    end
  end

  // sampled only here, so a reprogrammed boundary takes effect after the next reset
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      protect_boundary <= `BPR_DEFAULT;
    end else if (boot_load && !boot_done) begin
      protect_boundary <= arr_rdata;
    end
  end

  // the array output still holds the trim byte on the first edge after boot
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      osc_trim <= `TRIM_DEFAULT;
    end else if (boot_done && osc_trim_reload_pending) begin
      osc_trim <= arr_rdata;
    end
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      osc_trim_reload_pending <= 1'b1;
    end else if (boot_done) begin
      osc_trim_reload_pending <= 1'b0;
    end
  end

  // ****************
  // read path
  // ****************
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      rd_flash_q <= 1'b0;
      rd_ctl_q <= 1'b0;
    end else begin
      rd_flash_q <= reg_rd && in_flash;
      rd_ctl_q <= reg_rd && ctl_hit(reg_addr);
    end
  end

  // ****************
  // security
  // ****************
  // taken on the strobe edge so the mask lines up with the returned byte
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      hide_q <= 1'b0;
    end else begin
      hide_q <= ext_access && secured;
    end
  end

  always_comb begin
    reg_rdata = 8'h00;
    if (rd_ctl_q) begin
      reg_rdata = {4'h0, high_voltage_enable, mass_select, erase_select, program_select};
    end else if (rd_flash_q && !hide_q) begin
      reg_rdata = arr_rdata;
    end
  end

  // ****************
  // high voltage outputs
  // ****************
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      charge_pump_on <= 1'b0;
      high_voltage_array <= 1'b0;
    end else begin
      charge_pump_on <= high_voltage_enable;
      high_voltage_array <= high_voltage_enable;
    end
  end
endmodule : flash_program_erase_control

// [common/flash_ctl_params.svh]
`ifndef FLASH_CTL_PARAMS_SVH
`define FLASH_CTL_PARAMS_SVH
// ****************
// register map
// ****************
`define FCTL_OFF 16'hFE08
`define FBPR_OFF 16'hFFBE
`define FTRIM_OFF 16'hFFC0
`define FCTL_RESET 8'h00
`define FCTL_PGM_BIT 0
`define FCTL_ERASE_BIT 1
`define FCTL_MASS_BIT 2
`define FCTL_HIGH_VOLTAGE_ENABLE_BIT 3
`define FCTL_WMASK 8'h0F
// ****************
// array geometry
// ****************
`define FLASH_BASE 16'hC000
`define FLASH_AW 14
`define PAGE_LSB 6
`define ROW_LSB 5
`define ERASED_BYTE 8'hFF
`define BPR_NONE 8'hFF
`define TRIM_DEFAULT 8'h80
`define BPR_DEFAULT 8'hFF
`endif

// [common/flash_ctl_pkg.sv]
package flash_ctl_pkg;
  typedef enum logic [2:0] {
    SEQ_IDLE = 3'b000,
    SEQ_ARMED = 3'b001,
    SEQ_BPR_READ = 3'b010,
    SEQ_LATCHED = 3'b011,
    SEQ_HIGH_V = 3'b100
  } seq_state_e;
  typedef logic [7:0] byte_t;
  typedef logic [15:0] addr_t;
endpackage : flash_ctl_pkg

// [rtl/flash_array_mem.sv]
`timescale 1ns/1ps
`include "flash_ctl_params.svh"
module flash_array_mem
  import flash_ctl_pkg::*;
(
  // clock
  input wire logic sys_clk,
  // port
  input wire logic [`FLASH_AW-1:0] addr,
  input wire logic prog_en,
  input wire byte_t prog_data,
  input wire logic page_erase,
  input wire logic mass_erase,
  output byte_t rd_data
);
  // the array leaves the factory blank and keeps its contents through every reset
  byte_t cells [0:(1<<`FLASH_AW)-1] = '{default: `ERASED_BYTE};
  // ****************
  // array behaviour
  // ****************
  // erase sets bits to one, program can only clear bits
  always_ff @(posedge sys_clk) begin
    for (int i = 0; i < (1<<`FLASH_AW); i++) begin
      if (mass_erase) begin
        cells[i] <= `ERASED_BYTE;
      end else if (page_erase && ((i >> `PAGE_LSB) == (int'(addr) >> `PAGE_LSB))) begin
        cells[i] <= `ERASED_BYTE;
      end else if (prog_en && (i == int'(addr))) begin
        cells[i] <= cells[i] & prog_data;
      end
    end
    rd_data <= cells[addr];
  end
endmodule : flash_array_mem

// [rtl/flash_protect_check.sv]
`timescale 1ns/1ps
`include "flash_ctl_params.svh"
module flash_protect_check
  import flash_ctl_pkg::*;
(
  // inputs
  input wire byte_t boundary,
  input wire addr_t target,
  input wire logic mass_sel,
  // result
  output logic locked
);
  // protected range runs from boundary*64 above the flash base up to the top of memory
  always_comb begin
    if (boundary == `BPR_NONE) begin
      locked = 1'b0;
    end else if (mass_sel) begin
      locked = 1'b1;
    end else begin
      locked = (target >= (`FLASH_BASE + {2'b00, boundary, 6'h00})) || (target >= `FBPR_OFF);
    end
  end
endmodule : flash_protect_check

// [sim/flash_ctl_chk.sv]
`timescale 1ns/1ps
module flash_ctl_chk
  import flash_ctl_pkg::*;
(
  // clock and reset
  input wire logic sys_clk,
  input wire logic rst_n,
  // register port
  input wire addr_t reg_addr,
  input wire byte_t reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire byte_t reg_rdata,
  input wire logic ext_access,
  input wire logic secured,
  // status
  input wire logic charge_pump_on,
  input wire logic high_voltage_array,
  input wire byte_t osc_trim,
  input wire byte_t protect_boundary
);
  default clocking @(posedge sys_clk);
  endclocking
  default disable iff (!rst_n);
  // ***
  // boot load window
  // ***
  logic [2:0] boot;
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      boot <= 3'h0;
    end else if (boot != 3'h5) begin
      boot <= boot + 3'h1;
    end
  end
  chk_pump_pair: assert property (charge_pump_on == high_voltage_array)
    else $error("pump and array voltage differ");
  chk_rdata_idle: assert property (!$past(reg_rd) |-> reg_rdata == 8'h00)
    else $error("read data outside its cycle");
  chk_upper_zero: assert property ($past(reg_rd) && $past(reg_addr) == 16'hFE08 |-> reg_rdata[7:4] == 4'h0)
    else $error("control upper bits not zero");
  chk_sel_excl: assert property ($past(reg_rd) && $past(reg_addr) == 16'hFE08 |-> !(reg_rdata[1] && reg_rdata[0]))
    else $error("erase and program both set");
  chk_secure_hide: assert property ($past(reg_rd) && $past(ext_access) && $past(secured)
    && $past(reg_addr) >= 16'hC000 && $past(reg_addr) != 16'hFE08 |-> reg_rdata == 8'h00)
    else $error("secured array visible");
  chk_hv_cause: assert property ($rose(charge_pump_on) |-> $past(reg_wr, 2) && $past(reg_addr, 2) == 16'hFE08
    && ($past(reg_wdata, 2) & 8'h08) != 8'h00 && ($past(reg_wdata, 2) & 8'h03) != 8'h00)
    else $error("pump on without a proper write");
  chk_hv_drop: assert property (reg_wr && reg_addr == 16'hFE08 && !reg_wdata[3] |-> ##2 !charge_pump_on)
    else $error("pump stays on after clear");
  chk_boot_hold: assert property (boot == 3'h5 |-> $stable(protect_boundary) && $stable(osc_trim))
    else $error("loaded bytes changed after boot");
endmodule : flash_ctl_chk

bind flash_program_erase_control flash_ctl_chk u_chk (.sys_clk(sys_clk), .rst_n(rst_n), .reg_addr(reg_addr),
  .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .ext_access(ext_access),
  .secured(secured), .charge_pump_on(charge_pump_on), .high_voltage_array(high_voltage_array),
  .osc_trim(osc_trim), .protect_boundary(protect_boundary));

// [sim/flash_pump_model.sv]
`timescale 1ns/1ps
module flash_pump_model (
  // clock and reset
  input wire logic sys_clk,
  input wire logic rst_n,
  // high voltage
  input wire logic charge_pump_on,
  input wire logic high_voltage_array,
  // stress time
  output int hv_cycles
);
  // only pump and path together stress the array
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      hv_cycles <= 0;
    end else if (charge_pump_on && high_voltage_array) begin
      hv_cycles <= hv_cycles + 1;
    end
  end
endmodule : flash_pump_model

// [sim/flash_program_erase_control_test.sv]
`timescale 1ns/1ps
module flash_program_erase_control_test;
  import flash_ctl_pkg::*;
  logic sys_clk = 1'b0;
  logic rst_n = 1'b0;
  addr_t reg_addr = 16'h0000;
  byte_t reg_wdata = 8'h00;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic ext_access = 1'b0;
  logic secured = 1'b0;
  byte_t reg_rdata, osc_trim, protect_boundary, d;
  logic charge_pump_on, high_voltage_array;
  int error_cnt = 0;
  int samples_checked = 0;
  int cycles = 0;
  int hv_cycles;
  flash_program_erase_control dut (.sys_clk(sys_clk), .rst_n(rst_n), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .ext_access(ext_access),
    .secured(secured), .charge_pump_on(charge_pump_on), .high_voltage_array(high_voltage_array),
    .osc_trim(osc_trim), .protect_boundary(protect_boundary));
  flash_pump_model pump (.sys_clk(sys_clk), .rst_n(rst_n), .charge_pump_on(charge_pump_on),
    .high_voltage_array(high_voltage_array), .hv_cycles(hv_cycles));
  initial begin
    forever #4 sys_clk = ~sys_clk;
  end
  // run takes about 140 cycles
  always @(posedge sys_clk) begin
    cycles <= cycles + 1;
    if (cycles == 3000) begin
      error_cnt++;
      finish_test();
    end
  end
  // ***
  // tasks
  // ***
  task automatic check(input byte_t seen, input byte_t exp);
    samples_checked++;
    if (seen !== exp) begin
      error_cnt++;
      $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : check
  task automatic finish_test();
    $display("mismatches=%0d compares=%0d", error_cnt, samples_checked);
    if (error_cnt == 0 && samples_checked > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask : finish_test
  task automatic wr(input addr_t a, input byte_t v);
    @(posedge sys_clk);
    reg_addr <= a;
    reg_wdata <= v;
    reg_wr <= 1'b1;
    @(posedge sys_clk);
    reg_wr <= 1'b0;
  endtask : wr
  task automatic rd(input addr_t a, output byte_t v);
    @(posedge sys_clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge sys_clk);
    reg_rd <= 1'b0;
    #1;
    v = reg_rdata;
  endtask : rd
  task automatic rdc(input addr_t a, input byte_t exp);
    byte_t v;
    rd(a, v);
    check(v, exp);
  endtask : rdc
  // stray write b is dropped unless b lies in the same 32-byte row as a
  task automatic prog(input addr_t a, input byte_t v, input addr_t b);
    wr(16'hFE08, 8'h01);
    rd(16'hFFBE, d);
    wr(a, 8'hFF);
    wr(16'hFE08, 8'h09);
    wr(a, v);
    wr(b, 8'h00);
    wr(16'hFE08, 8'h08);
    wr(16'hFE08, 8'h00);
  endtask : prog
  task automatic erase(input addr_t a, input byte_t m, input byte_t pump_exp);
    wr(16'hFE08, m);
    rd(16'hFFBE, d);
    wr(a, 8'hFF);
    wr(16'hFE08, m | 8'h08);
    @(posedge sys_clk);
    #1;
    check({7'h00, charge_pump_on}, pump_exp);
    wr(16'hFE08, 8'h08);
    wr(16'hFE08, 8'h00);
  endtask : erase
  // ***
  // sequence
  // ***
  initial begin
    repeat (10) @(posedge sys_clk);
    rst_n <= 1'b1;
    repeat (5) @(posedge sys_clk);
    rdc(16'hFE08, 8'h00);
    check(protect_boundary, 8'hFF);
    check(osc_trim, 8'hFF);
    wr(16'hFE08, 8'hF1);
    rdc(16'hFE08, 8'h01);
    wr(16'hFE08, 8'h09);
    rdc(16'hFE08, 8'h01);
    wr(16'hFE08, 8'h03);
    rd(16'hFE08, d);
    check({7'h00, d[1] & d[0]}, 8'h00);
    wr(16'hFE08, 8'h00);
    prog(16'hC020, 8'h00, 16'hC020);
    prog(16'hC050, 8'h3C, 16'hC060);
    rdc(16'hC050, 8'h3C);
    rdc(16'hC060, 8'hFF);
    @(posedge sys_clk);
    secured <= 1'b1;
    ext_access <= 1'b1;
    rdc(16'hC050, 8'h00);
    @(posedge sys_clk);
    secured <= 1'b0;
    ext_access <= 1'b0;
    erase(16'hC07F, 8'h02, 8'h01);
    rdc(16'hC050, 8'hFF);
    rdc(16'hC020, 8'h00);
    erase(16'hC0C0, 8'h06, 8'h01);
    rdc(16'hC020, 8'hFF);
    check({7'h00, hv_cycles > 0}, 8'h01);
    prog(16'hFFBE, 8'hFE, 16'hFFA0);
    rst_n <= 1'b0;
    repeat (2) @(posedge sys_clk);
    rst_n <= 1'b1;
    repeat (5) @(posedge sys_clk);
    check(protect_boundary, 8'hFE);
    erase(16'hFFC0, 8'h02, 8'h00);
    finish_test();
  end
endmodule : flash_program_erase_control_test
